// ---- inc/sra_params.svh ----
`ifndef SRA_PARAMS_SVH
`define SRA_PARAMS_SVH

// ==========================================================
// frame layout
`define SRA_ADDR_BITS 15
`define SRA_DATA_BITS 8
`define SRA_CNT_BITS 5
`define SRA_CNT_ZERO 5'h00
`define SRA_CNT_STEP 5'h01
// rising edge index of the last header bit and the last data bit
`define SRA_CNT_HDR_LAST 5'h0f
`define SRA_CNT_FRAME_LAST 5'h17
`define SRA_DIR_READ 1'b1

// ==========================================================
// storage defaults
`define SRA_REG_RESET 8'h00
`define SRA_DEPTH_DEFAULT 16
`define SRA_IDX_W_DEFAULT 4

`endif

// ---- inc/sra_pkg.sv ----
// ==========================================================
// shared types
package sra_pkg;

	typedef enum logic [1:0] {
		SRA_IDLE = 2'b00,
		SRA_HDR = 2'b01,
		SRA_DATA = 2'b10,
		SRA_DONE = 2'b11
	} sra_state_t;

endpackage : sra_pkg

// ---- logic/sra_port.sv ----
`timescale 1ns/1ns
`include "sra_params.svh"

module sra_port #(
	parameter int DEPTH = `SRA_DEPTH_DEFAULT,
	parameter int IDX_W = `SRA_IDX_W_DEFAULT
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// serial pins
	input wire logic serial_select_n,
	input wire logic serial_clk,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_out_oe_n,
	// core side
	output logic [DEPTH*`SRA_DATA_BITS-1:0] reg_image,
	output logic wr_pulse,
	output logic [`SRA_ADDR_BITS-1:0] wr_addr,
	output logic [`SRA_DATA_BITS-1:0] wr_data,
	output logic abort_pulse
);

	localparam logic [`SRA_ADDR_BITS-1:0] ADDR_LIM = `SRA_ADDR_BITS'(DEPTH);

	// ==========================================================
	// pin synchronisers
	logic sel_s1_q, sel_s2_q;
	logic clk_s1_q, clk_s2_q, clk_s3_q;
	logic din_s1_q, din_s2_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sel_s1_q <= 1'b1;
			sel_s2_q <= 1'b1;
		end else begin
			sel_s1_q <= serial_select_n;
			sel_s2_q <= sel_s1_q;
		end
	end

	// third stage only remembers the previous synchronised level
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			clk_s1_q <= 1'b0;
			clk_s2_q <= 1'b0;
			clk_s3_q <= 1'b0;
		end else begin
			clk_s1_q <= serial_clk;
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
		end
	end

	// data goes through the same depth as the clock, so they stay aligned
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			din_s1_q <= 1'b0;
			din_s2_q <= 1'b0;
		end else begin
			din_s1_q <= serial_data_in;
			din_s2_q <= din_s1_q;
		end
	end

	logic selected, sclk_rise, sclk_fall;

	assign selected = ~sel_s2_q;
	assign sclk_rise = clk_s2_q & ~clk_s3_q;
	assign sclk_fall = ~clk_s2_q & clk_s3_q;

	// ==========================================================
	// frame state
	sra_pkg::sra_state_t state_q;
	logic [`SRA_CNT_BITS-1:0] cnt_q;
	logic [`SRA_ADDR_BITS-1:0] rx_q;
	logic dir_q;
	logic [`SRA_ADDR_BITS-1:0] addr_q;

	logic shift_en, hdr_done, frame_done, do_write;
	logic [`SRA_ADDR_BITS-1:0] hdr_addr;
	logic [`SRA_DATA_BITS-1:0] rx_byte;

	// edge-driven only: no count of ref_clk ever limits a bit period
	assign shift_en = selected && sclk_rise &&
		(state_q == sra_pkg::SRA_HDR || state_q == sra_pkg::SRA_DATA);
	assign hdr_done = shift_en && (cnt_q == `SRA_CNT_HDR_LAST);
	assign frame_done = shift_en && (cnt_q == `SRA_CNT_FRAME_LAST);
	// header is rx_q[14] direction, then address msb first
	assign hdr_addr = {rx_q[`SRA_ADDR_BITS-2:0], din_s2_q};
	assign rx_byte = {rx_q[`SRA_DATA_BITS-2:0], din_s2_q};
	assign do_write = frame_done && (dir_q != `SRA_DIR_READ);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= sra_pkg::SRA_IDLE;
		end else if (!selected) begin
			state_q <= sra_pkg::SRA_IDLE;
		end else begin
			case (state_q)
				sra_pkg::SRA_IDLE: begin
					state_q <= sra_pkg::SRA_HDR;
				end
				sra_pkg::SRA_HDR: begin
					if (hdr_done) begin
						state_q <= sra_pkg::SRA_DATA;
					end
				end
				sra_pkg::SRA_DATA: begin
					if (frame_done) begin
						state_q <= sra_pkg::SRA_DONE;
					end
				end
				// extra clocks are not streamed; wait for release
				sra_pkg::SRA_DONE: begin
					state_q <= sra_pkg::SRA_DONE;
				end
				default: begin
					state_q <= sra_pkg::SRA_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= `SRA_CNT_ZERO;
		end else if (!selected) begin
			cnt_q <= `SRA_CNT_ZERO;
		end else if (shift_en) begin
			cnt_q <= cnt_q + `SRA_CNT_STEP;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_q <= '0;
		end else if (shift_en) begin
			rx_q <= hdr_addr;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dir_q <= 1'b0;
			addr_q <= '0;
		end else if (hdr_done) begin
			dir_q <= rx_q[`SRA_ADDR_BITS-1];
			addr_q <= hdr_addr;
		end
	end

	// ==========================================================
	// register storage
	logic wr_hit, rd_hit;
	logic [`SRA_DATA_BITS-1:0] rd_byte;
	logic [DEPTH*`SRA_DATA_BITS-1:0] image;

	assign wr_hit = do_write && (addr_q < ADDR_LIM);
	assign rd_hit = hdr_addr < ADDR_LIM;

	sra_regfile #(
		.DEPTH(DEPTH),
		.IDX_W(IDX_W)
	) u_regs (
		.ref_clk(ref_clk),
		.rst(rst),
		.wr_en(wr_hit),
		.wr_idx(addr_q[IDX_W-1:0]),
		.wr_data(rx_byte),
		.rd_idx(hdr_addr[IDX_W-1:0]),
		.rd_data(rd_byte),
		.image(image)
	);

	assign reg_image = image;

	// ==========================================================
	// core-side notifications
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_pulse <= 1'b0;
			wr_addr <= '0;
			wr_data <= `SRA_REG_RESET;
		end else begin
			wr_pulse <= do_write;
			if (do_write) begin
				wr_addr <= addr_q;
				wr_data <= rx_byte;
			end
		end
	end

	// a select pulse with no clock at all is not reported
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			abort_pulse <= 1'b0;
		end else begin
			abort_pulse <= !selected && (cnt_q != `SRA_CNT_ZERO) &&
				(state_q == sra_pkg::SRA_HDR ||
				state_q == sra_pkg::SRA_DATA);
		end
	end

	// ==========================================================
	// read data output
	logic [`SRA_DATA_BITS-1:0] tx_q;
	logic tx_fall;

	// data input is never looked at here during a read byte
	assign tx_fall = selected && sclk_fall &&
		(state_q == sra_pkg::SRA_DATA) && (dir_q == `SRA_DIR_READ);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_q <= '0;
		end else if (hdr_done) begin
			// unimplemented addresses read back as zero
			tx_q <= rd_hit ? rd_byte : '0;
		end else if (tx_fall) begin
			tx_q <= {tx_q[`SRA_DATA_BITS-2:0], 1'b0};
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			serial_data_out <= 1'b0;
			serial_data_out_oe_n <= 1'b1;
		end else if (!selected) begin
			serial_data_out <= 1'b0;
			serial_data_out_oe_n <= 1'b1;
		end else if (tx_fall) begin
			serial_data_out <= tx_q[`SRA_DATA_BITS-1];
			serial_data_out_oe_n <= 1'b0;
		end
	end

endmodule : sra_port

// ---- logic/sra_regfile.sv ----
`timescale 1ns/1ns
`include "sra_params.svh"

// ==========================================================
// byte-wide register storage, one flop byte per address
module sra_regfile #(
	parameter int DEPTH = `SRA_DEPTH_DEFAULT,
	parameter int IDX_W = `SRA_IDX_W_DEFAULT
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// write port
	input wire logic wr_en,
	input wire logic [IDX_W-1:0] wr_idx,
	input wire logic [`SRA_DATA_BITS-1:0] wr_data,
	// read port
	input wire logic [IDX_W-1:0] rd_idx,
	output logic [`SRA_DATA_BITS-1:0] rd_data,
	// whole image, byte i at bits 8i+7..8i
	output logic [DEPTH*`SRA_DATA_BITS-1:0] image
);

	logic [`SRA_DATA_BITS-1:0] mem_q [DEPTH];

	// ==========================================================
	// storage
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_byte
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					mem_q[gi] <= `SRA_REG_RESET;
				end else if (wr_en && (wr_idx == IDX_W'(gi))) begin
					mem_q[gi] <= wr_data;
				end
			end
			// lowest address holds the least significant byte
			assign image[gi*`SRA_DATA_BITS +: `SRA_DATA_BITS] = mem_q[gi];
		end
	endgenerate

	assign rd_data = mem_q[rd_idx];

endmodule : sra_regfile

// ---- test/sra_host.sv ----
`timescale 1ns/1ns
// =====
// host driving the serial link
module sra_host (
	// serial pins
	output logic serial_select_n,
	output logic serial_clk,
	output logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic serial_data_out_oe_n
);
	initial begin
		serial_select_n = 1'b1;
		serial_clk = 1'b0;
		serial_data_in = 1'b0;
	end
	// clock stands low between frames; released data flips, never holds
	task automatic frame(input logic [23:0] f, input int n, input int hp,
		input bit sel, output logic [7:0] rd, output logic ok);
		rd = 8'h00;
		ok = 1'b1;
		serial_select_n = !sel;
		#(hp);
		for (int i = 0; i < n; i++) begin
			serial_data_in = f[23-i];
			#(hp);
			if (i >= 16 && f[23]) begin
				rd = {rd[6:0], serial_data_out};
				ok &= !serial_data_out_oe_n;
			end else begin
				ok &= serial_data_out_oe_n;
			end
			serial_clk = 1'b1;
			#(hp);
			serial_clk = 1'b0;
		end
		#(hp);
		serial_select_n = 1'b1;
		serial_data_in = !serial_data_in;
		#(hp * 3);
	endtask : frame
endmodule : sra_host

// ---- test/sra_port_props.sv ----
`timescale 1ns/1ns
// =====
// pin-level checker
module sra_port_props #(
	parameter int DEPTH = 16,
	parameter int IDX_W = 4
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// serial pins
	input wire logic serial_select_n,
	input wire logic serial_clk,
	input wire logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic serial_data_out_oe_n,
	// core side
	input wire logic [DEPTH*8-1:0] reg_image,
	input wire logic wr_pulse,
	input wire logic [14:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic abort_pulse
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	idle_float_a: assert property (
		serial_select_n && $past(serial_select_n, 5) |-> serial_data_out_oe_n)
		else $error("output driven while idle");
	drive_sel_a: assert property (
		!serial_data_out_oe_n |-> !$past(serial_select_n, 5))
		else $error("drive without select");
	float_zero_a: assert property (
		serial_data_out_oe_n |-> !serial_data_out)
		else $error("data while floating");
	fall_only_a: assert property (
		(serial_clk && !serial_data_out_oe_n)[*6] |-> $stable(serial_data_out))
		else $error("data moved while clock high");
	wr_once_a: assert property (wr_pulse |=> !wr_pulse)
		else $error("write pulse too long");
	wr_sel_a: assert property (wr_pulse |-> !serial_select_n)
		else $error("write outside frame");
	wr_hold_a: assert property (
		!wr_pulse |-> $stable(wr_addr) && $stable(wr_data))
		else $error("write fields moved");
	image_wr_a: assert property ($changed(reg_image) |-> wr_pulse)
		else $error("storage changed without write");
	abort_excl_a: assert property (!(abort_pulse && wr_pulse))
		else $error("abort with write");
	cover property (wr_pulse);
	cover property (abort_pulse);
	cover property ($fell(serial_data_out_oe_n));
endmodule : sra_port_props

bind sra_port sra_port_props #(.DEPTH(DEPTH), .IDX_W(IDX_W)) u_props (
	.ref_clk, .rst, .serial_select_n, .serial_clk, .serial_data_in,
	.serial_data_out, .serial_data_out_oe_n, .reg_image, .wr_pulse,
	.wr_addr, .wr_data, .abort_pulse);

// ---- test/sra_port_tb.sv ----
`timescale 1ns/1ns
// =====
// bench for the serial register port
module sra_port_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic serial_select_n, serial_clk, serial_data_in, serial_data_out;
	logic serial_data_out_oe_n, wr_pulse, abort_pulse, ok;
	logic [127:0] reg_image;
	logic [14:0] wr_addr;
	logic [7:0] wr_data, rd;
	int err_total = 0, n_checks = 0, n_wr = 0, n_ab = 0;

	sra_host host (.serial_select_n, .serial_clk, .serial_data_in,
		.serial_data_out, .serial_data_out_oe_n);
	sra_port #(.DEPTH(16), .IDX_W(4)) dut (.ref_clk, .rst, .serial_select_n,
		.serial_clk, .serial_data_in, .serial_data_out, .serial_data_out_oe_n,
		.reg_image, .wr_pulse, .wr_addr, .wr_data, .abort_pulse);

	always #50 ref_clk = !ref_clk;
	always @(posedge ref_clk) begin
		n_wr <= n_wr + wr_pulse;
		n_ab <= n_ab + abort_pulse;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	task automatic t_reset;
		rst = 1'b1;
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		for (int i = 0; i < 4; i++) begin
			chk(reg_image[i*32 +: 32], 32'h0);
		end
		chk({serial_data_out_oe_n, serial_data_out, wr_pulse}, 32'h4);
	endtask : t_reset
	task automatic t_write_read;
		host.frame({1'b0, 15'h0003, 8'ha5}, 24, 400, 1'b1, rd, ok);
		chk({n_wr[7:0], wr_addr, wr_data}, {8'h1, 15'h3, 8'ha5});
		chk({ok, reg_image[31:24]}, 9'h1a5);
		host.frame({1'b1, 15'h0003, 8'h5a}, 24, 400, 1'b1, rd, ok);
		chk({ok, rd, n_wr[7:0]}, 17'h1a501);
	endtask : t_write_read
	task automatic t_le;
		host.frame({1'b0, 15'h0004, 8'h34}, 24, 400, 1'b1, rd, ok);
		host.frame({1'b0, 15'h0005, 8'h12}, 24, 1200, 1'b1, rd, ok);
		chk({ok, reg_image[47:32]}, 17'h11234);
		host.frame({1'b1, 15'h0005, 8'hff}, 24, 1200, 1'b1, rd, ok);
		chk({ok, rd}, 9'h112);
	endtask : t_le
	task automatic t_abort;
		host.frame({1'b0, 15'h0003, 8'h00}, 20, 400, 1'b1, rd, ok);
		chk({n_ab[3:0], n_wr[3:0], reg_image[31:24]}, 16'h13a5);
		host.frame({1'b0, 15'h0003, 8'hff}, 24, 400, 1'b0, rd, ok);
		chk({n_ab[3:0], n_wr[3:0], reg_image[31:24]}, 16'h13a5);
		host.frame({1'b0, 15'h7f00, 8'h77}, 24, 400, 1'b1, rd, ok);
		chk({n_wr[7:0], wr_addr, reg_image[7:0]}, {8'h4, 15'h7f00, 8'h0});
		host.frame({1'b1, 15'h4003, 8'h00}, 24, 400, 1'b1, rd, ok);
		chk({ok, rd}, 9'h100);
	endtask : t_abort

	initial begin
		t_reset();
		t_write_read();
		t_le();
		t_abort();
		t_reset();
		give_verdict();
	end
	initial begin
		#500000;
		err_total++;
		give_verdict();
	end
endmodule : sra_port_tb
